// File: hdl/serdes_link_map.vh
// Constants for the serdes link lock and synchronisation block
`ifndef SERDES_LINK_MAP_VH
`define SERDES_LINK_MAP_VH
`define WORD_BITS       10
`define FRAME_BITS      12
`define PHASE_LAST      4'hB
`define PHASE_HALF      4'h6
`define SYNC_WORD       10'h3E0
`define LOSS_RUN        3'h4
`define CONFIRM_RUN     3'h4
`define REF_TIMEOUT     8'h40
`endif

// File: hdl/serdes_link_lock_sync.v
// Serializer framing and deserializer lock supervision for one serial lane
//
// Overview of operation
// [R1] Frame each word with two clock bits
// [R2] Reference timebase must run for lock
// [R3] Lock indicator high whenever lock is lost
// [R4] Outputs high impedance until first lock; here only parallel_out floats, recovered_clock stays driven low
// [R5] Either sync request sends sync patterns
// [R6] Lock indicator may drive sync request
// [R7] Random lock acquires on arbitrary data
// [R8] Output words valid while lock indicator low
// [R9] Loss after four consecutive bad clock bits
// [R10] Up to three corrupt words before loss
// [R11] Partner treats three prior words suspect
// [R12] Relock by sync patterns or random lock
// [R13] Lock indicator high in sleep, before lock
// [R14] Partner holds sync for 1024 symbols
// [R15] Output enable low floats data and clock; here it floats parallel_out only, recovered_clock stays driven
// [R16] Sleep stops link and floats outputs; here ser_out and parallel_out float, recovered_clock stays driven low
// [R17] Edge select picks capture edge
`timescale 1ns/100ps
`include "serdes_link_map.vh"

module serdes_link_lock_sync (
  input  wire        mclk,
  input  wire        resetn,
  input  wire        sleep_n,
  input  wire        tx_word_clock,
  input  wire        tx_edge_select,
  input  wire [9:0]  data_in,
  input  wire        sync_request_a,
  input  wire        sync_request_b,
  output wire        ser_out,
  output wire        ser_out_en_n,
  input  wire        ser_in,
  input  wire        reference_timebase,
  input  wire        rx_output_enable,
  output wire [9:0]  parallel_out,
  output wire        parallel_out_en_n,
  output wire        recovered_clock,
  output wire        lock_n
);

  // One-hot receive states
  localparam [1:0] ST_HUNT   = 2'h1; // Searching for frame alignment
  localparam [1:0] ST_LOCKED = 2'h2; // Aligned, supervising clock bits

  // Pin synchronisers, two stages each
  reg  [1:0]  sleep_sync_reg;      // Sleep input
  reg  [1:0]  tck_sync_reg;        // Transmit word clock
  reg         tck_prev_reg;        // Last settled word clock level
  reg  [1:0]  edge_sync_reg;       // Edge select
  reg  [9:0]  din_s1_reg;          // Data first stage
  reg  [9:0]  din_s2_reg;          // Data second stage
  reg  [1:0]  syna_sync_reg;       // Sync request a
  reg  [1:0]  synb_sync_reg;       // Sync request b
  reg  [1:0]  rx_sync_reg;         // Serial lane input
  reg  [1:0]  ref_sync_reg;        // Reference timebase
  reg         ref_prev_reg;        // Last settled reference level
  reg  [1:0]  oe_sync_reg;         // Output enable

  wire awake     = sleep_sync_reg[1];
  wire tck_rise  = tck_sync_reg[1] & ~tck_prev_reg;
  wire tck_fall  = ~tck_sync_reg[1] & tck_prev_reg;

  // All pin inputs but resetn pass two flops before use
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sleep_sync_reg <= 2'h0;
      tck_sync_reg   <= 2'h0;
      tck_prev_reg   <= 1'b0;
      edge_sync_reg  <= 2'h0;
      din_s1_reg     <= 10'h000;
      din_s2_reg     <= 10'h000;
      syna_sync_reg  <= 2'h0;
      synb_sync_reg  <= 2'h0;
      rx_sync_reg    <= 2'h0;
      ref_sync_reg   <= 2'h0;
      ref_prev_reg   <= 1'b0;
      oe_sync_reg    <= 2'h0;
    end else begin
      sleep_sync_reg <= {sleep_sync_reg[0], sleep_n};
      tck_sync_reg   <= {tck_sync_reg[0], tx_word_clock};
      tck_prev_reg   <= tck_sync_reg[1];
      edge_sync_reg  <= {edge_sync_reg[0], tx_edge_select};
      din_s1_reg     <= data_in;
      din_s2_reg     <= din_s1_reg;
      syna_sync_reg  <= {syna_sync_reg[0], sync_request_a};
      synb_sync_reg  <= {synb_sync_reg[0], sync_request_b};
      rx_sync_reg    <= {rx_sync_reg[0], ser_in};
      ref_sync_reg   <= {ref_sync_reg[0], reference_timebase};
      ref_prev_reg   <= ref_sync_reg[1];
      oe_sync_reg    <= {oe_sync_reg[0], rx_output_enable};
    end
  end

  // ---------------- Serializer ----------------
  reg  [9:0]  hold_reg;            // Last captured parallel word
  reg  [11:0] tx_shift_reg;        // Frame being sent, MSB first
  reg  [3:0]  tx_phase_reg;        // Bit position within frame
  reg         ser_out_reg;         // Lane level
  wire        capture  = edge_sync_reg[1] ? tck_rise : tck_fall; // R17
  wire        send_syn = syna_sync_reg[1] | synb_sync_reg[1];      // R5
  wire [9:0]  tx_word  = send_syn ? `SYNC_WORD : hold_reg;         // R5

  // Word capture and frame shifter; only the newest word is framed,
  // so a word clock faster than one frame per 12 cycles drops words
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hold_reg     <= 10'h000;
      tx_shift_reg <= 12'h000;
      tx_phase_reg <= 4'h0;
      ser_out_reg  <= 1'b0;
    end else if (!awake) begin // R16
      tx_phase_reg <= 4'h0;
      ser_out_reg  <= 1'b0;
    end else begin
      if (capture) begin
        hold_reg <= din_s2_reg; // R17
      end
      if (tx_phase_reg == 4'h0) begin
        // Start bit high, stop bit low: a rising edge every frame
        tx_shift_reg <= {1'b1, tx_word, 1'b0}; // R1
        ser_out_reg  <= 1'b1;                  // R1
      end else begin
        ser_out_reg  <= tx_shift_reg[11 - tx_phase_reg];
      end
      tx_phase_reg <= (tx_phase_reg == `PHASE_LAST) ? 4'h0 : tx_phase_reg + 4'h1;
    end
  end

  assign ser_out      = ser_out_reg;
  assign ser_out_en_n = ~awake; // R16

  // ---------------- Deserializer ----------------
  reg  [7:0]  ref_idle_reg;        // Cycles since last reference edge
  reg         ref_ok_reg;          // Reference timebase seen running
  reg  [11:0] window_reg;          // Last twelve lane bits
  reg  [1:0]  state_reg;           // Hunt or locked
  reg  [1:0]  state_next;
  reg  [3:0]  rx_phase_reg;        // Position in aligned frame
  reg  [3:0]  rx_phase_next;
  reg  [2:0]  good_reg;            // Consecutive good frames in hunt
  reg  [2:0]  good_next;
  reg  [2:0]  bad_reg;             // Consecutive bad frames while locked
  reg  [2:0]  bad_next;
  reg  [9:0]  word_reg;            // Presented parallel word
  reg         rclk_reg;            // Recovered word clock
  reg         seen_lock_reg;       // Set once after first lock

  wire frame_ok = window_reg[11] & ~window_reg[0];
  wire is_sync  = frame_ok & (window_reg[10:1] == `SYNC_WORD);
  wire boundary = (rx_phase_reg == `PHASE_LAST);
  wire locked   = (state_reg == ST_LOCKED);

  // Reference activity watch; a stopped reference cannot hold lock
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ref_idle_reg <= 8'h00;
      ref_ok_reg   <= 1'b0;
    end else if (ref_sync_reg[1] != ref_prev_reg) begin
      ref_idle_reg <= 8'h00;
      ref_ok_reg   <= 1'b1; // R2
    end else if (ref_idle_reg == `REF_TIMEOUT) begin
      ref_ok_reg   <= 1'b0; // R2
    end else begin
      ref_idle_reg <= ref_idle_reg + 8'h01;
    end
  end

  // Lock search and supervision
  always @* begin
    state_next    = state_reg;
    good_next     = good_reg;
    bad_next      = bad_reg;
    rx_phase_next = (rx_phase_reg == `PHASE_LAST) ? 4'h0 : rx_phase_reg + 4'h1;
    case (state_reg)
      ST_HUNT: begin
        bad_next = 3'h0;
        if (good_reg == 3'h0) begin
          // Any framed window starts a candidate alignment
          if (frame_ok) begin
            rx_phase_next = 4'h0;
            if (is_sync) begin
              state_next = ST_LOCKED; // R12
            end else begin
              good_next = 3'h1; // R7
            end
          end
        end else if (boundary) begin
          if (!frame_ok) begin
            good_next = 3'h0; // Alignment was false, hunt again
          end else if (is_sync || good_reg == `CONFIRM_RUN - 3'h1) begin
            state_next = ST_LOCKED; // R7 R12
            good_next  = 3'h0;
          end else begin
            good_next = good_reg + 3'h1;
          end
        end
      end
      ST_LOCKED: begin
        if (boundary) begin
          if (frame_ok) begin
            bad_next = 3'h0;
          end else if (bad_reg == `LOSS_RUN - 3'h1) begin
            state_next = ST_HUNT; // R9 R3
            bad_next   = 3'h0;
          end else begin
            bad_next = bad_reg + 3'h1; // R9
          end
        end
      end
      default: begin
        state_next = ST_HUNT;
        good_next  = 3'h0;
        bad_next   = 3'h0;
      end
    endcase
    // Sleep or a dead reference forces the hunt
    if (!awake || !ref_ok_reg) begin
      state_next = ST_HUNT; // R16 R2
      good_next  = 3'h0;
      bad_next   = 3'h0;
    end
  end

  // Receive registers
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      window_reg    <= 12'h000;
      state_reg     <= ST_HUNT;
      rx_phase_reg  <= 4'h0;
      good_reg      <= 3'h0;
      bad_reg       <= 3'h0;
      word_reg      <= 10'h000;
      rclk_reg      <= 1'b0;
      seen_lock_reg <= 1'b0;
    end else begin
      window_reg   <= {window_reg[10:0], rx_sync_reg[1]};
      state_reg    <= state_next;
      rx_phase_reg <= rx_phase_next;
      good_reg     <= good_next;
      bad_reg      <= bad_next;
      // Words of bad frames still pass until loss is declared
      if (locked && boundary) begin
        word_reg <= window_reg[10:1]; // R8 R10
      end
      rclk_reg <= locked & (rx_phase_reg < `PHASE_HALF);
      if (locked) begin
        seen_lock_reg <= 1'b1; // R4
      end
    end
  end

  assign parallel_out      = word_reg;
  assign recovered_clock   = rclk_reg;
  // Drive only after first lock, while enabled and awake
  assign parallel_out_en_n = ~(seen_lock_reg & oe_sync_reg[1] & awake); // R4 R15 R16
  assign lock_n            = ~locked; // R3 R13

endmodule // serdes_link_lock_sync

// File: verification/serdes_link_lock_sync_asserts.sv
// Checker for the serdes link lock block
`timescale 1ns/100ps
module serdes_link_lock_sync_asserts (
  input wire       mclk,
  input wire       resetn,
  input wire       sleep_n,
  input wire       sync_request_a,
  input wire       sync_request_b,
  input wire       ser_out,
  input wire       ser_out_en_n,
  input wire       rx_output_enable,
  input wire [9:0] parallel_out,
  input wire       parallel_out_en_n,
  input wire       recovered_clock,
  input wire       lock_n
);
  reg [5:0] run_cnt;   // Awake cycles with a sync request up
  reg       seen_lock; // Lock reached since reset
  // Saturates so a long sync burst never wraps back
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      run_cnt   <= 6'h00;
      seen_lock <= 1'b0;
    end else begin
      run_cnt   <= (sleep_n && (sync_request_a || sync_request_b)) ?
                   run_cnt + {5'h00, run_cnt != 6'h3F} : 6'h00;
      seen_lock <= seen_lock || !lock_n;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Sync frame: start, 0x3E0, stop
  sequence s_sync_frame;
    ser_out[*6] ##1 !ser_out[*6];
  endsequence
  // Recovered clock high six phases
  sequence s_rclk_pulse;
    recovered_clock[*6] ##1 !recovered_clock;
  endsequence
  a_sync_frame_shape: assert property (run_cnt > 6'h1E && $rose(ser_out) |-> s_sync_frame)
    else $error("bad sync frame");
  a_sleep_floats: assert property ((!sleep_n)[*4] |-> ser_out_en_n && lock_n && parallel_out_en_n)
    else $error("sleep outputs driven");
  a_awake_drives: assert property (sleep_n[*4] |-> !ser_out_en_n)
    else $error("lane not driven");
  a_oe_floats: assert property ((!rx_output_enable)[*4] |-> parallel_out_en_n)
    else $error("outputs driven while disabled");
  a_prelock_floats: assert property (!seen_lock && lock_n |-> parallel_out_en_n)
    else $error("outputs driven before lock");
  a_rclk_idle: assert property (lock_n[*2] |-> !recovered_clock)
    else $error("clock while unlocked");
  a_rclk_pulse: assert property ($rose(recovered_clock) |-> s_rclk_pulse or ##[1:12] lock_n)
    else $error("bad recovered clock");
  a_word_stands: assert property (!lock_n && $changed(parallel_out) |=> $stable(parallel_out)[*8])
    else $error("word changed mid frame");
endmodule // serdes_link_lock_sync_asserts
bind serdes_link_lock_sync serdes_link_lock_sync_asserts i_chk (.mclk, .resetn, .sleep_n,
  .sync_request_a, .sync_request_b, .ser_out, .ser_out_en_n, .rx_output_enable,
  .parallel_out, .parallel_out_en_n, .recovered_clock, .lock_n);

// File: verification/lane_partner.sv
// Far end serializer model feeding the receive lane
`timescale 1ns/100ps
module lane_partner (
  input  wire       mclk,
  input  wire       resetn,
  input  wire [9:0] word,  // Word repeated every frame
  input  wire       bad,   // Inverted clock bits
  input  wire       sync,  // Send the sync pattern instead of word
  output reg        lane   // Serial bit to the receiver
);
  reg [3:0]  phase; // Bit slot in the frame
  reg [11:0] frame; // Bits still to send
  // Word loaded only at slot 0 so frames are never torn
  // Rising edge keeps clear of the bench driving on the falling edge
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      phase <= 4'h0;
      frame <= 12'h000;
      lane  <= 1'b0;
    end else begin
      phase <= (phase == 4'hB) ? 4'h0 : phase + 4'h1;
      frame <= (phase == 4'h0) ? {(sync ? 10'h3E0 : word), bad, 1'b0} : frame << 1;
      lane  <= (phase == 4'h0) ? ~bad : frame[11];
    end
  end
endmodule // lane_partner

// File: verification/serdes_link_lock_sync_tb.sv
// Self-checking bench for the serdes link lock block
`timescale 1ns/100ps
module serdes_link_lock_sync_tb;
  reg        mclk, resetn, sleep_n, tx_word_clock, tx_edge_select, bad, hit;
  reg        sync_request_a, sync_request_b, rx_output_enable, reference_timebase;
  reg        loop_en;   // Lock indicator fed back to far sync request
  reg  [9:0] data_in, rx_word;
  reg [11:0] win;       // Last twelve lane bits
  wire       ser_out, ser_out_en_n, ser_in, parallel_out_en_n, recovered_clock, lock_n;
  wire [9:0] parallel_out;
  integer    error_cnt, n_checks, i;
  serdes_link_lock_sync i_serdes_link_lock_sync (.mclk, .resetn, .sleep_n, .tx_word_clock,
    .tx_edge_select, .data_in, .sync_request_a, .sync_request_b, .ser_out, .ser_out_en_n,
    .ser_in, .reference_timebase, .rx_output_enable, .parallel_out, .parallel_out_en_n,
    .recovered_clock, .lock_n);
  lane_partner i_lane_partner (.mclk, .resetn, .word(rx_word), .bad,
    .sync(loop_en & lock_n), .lane(ser_in));
  initial begin mclk = 0; forever #4 mclk = ~mclk; end
  initial begin tx_word_clock = 0; forever #40 tx_word_clock = ~tx_word_clock; end
  initial begin reference_timebase = 0; forever #16 reference_timebase = ~reference_timebase; end
  always @(posedge mclk) win <= {win[10:0], ser_out};
  task cyc(input integer n); repeat (n) @(negedge mclk); endtask
  task chk(input string what, input [11:0] seen, input [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Looks for one whole frame anywhere in the next 80 bits
  task seek(input [11:0] exp);
    hit = 0;
    repeat (80) begin @(negedge mclk); if (win === exp) hit = 1; end
  endtask
  task t_idle;
    chk("lock_n", lock_n, 1);
    chk("rx en_n", parallel_out_en_n, 1);
  endtask
  task t_sync_tx; // First burst held for 1024 symbols
    for (i = 0; i < 2; i++) begin
      {sync_request_b, sync_request_a} = 2'b01 << i;
      cyc(i ? 40 : 12300);
      seek(12'hFC0);
      chk("sync frame", hit, 1);
    end
    {sync_request_b, sync_request_a} = 2'b00;
  endtask
  task t_data_tx;
    for (i = 0; i < 2; i++) begin
      tx_edge_select = i;
      data_in = i ? 10'h2A5 : 10'h15A;
      cyc(60);
      seek({1'b1, data_in, 1'b0});
      chk("data frame", hit, 1);
    end
  endtask
  task t_rx_lock;
    bad = 0;
    rx_word = 10'h3E0;
    cyc(110); // Earlier false lock on bad frames must be lost first
    chk("sync lock", lock_n, 0);
    rx_word = 10'h155;
    cyc(40);
    chk("word", parallel_out, 10'h155);
    chk("rx en_n", parallel_out_en_n, 0);
    rx_output_enable = 0;
    cyc(5);
    chk("oe en_n", parallel_out_en_n, 1);
    rx_output_enable = 1;
  endtask
  task t_loss_relock; // One rising edge per frame, so one alignment only
    bad = 1;
    cyc(40);
    chk("lock early", lock_n, 0);
    cyc(25);
    chk("lock lost", lock_n, 1);
    bad = 0;
    rx_word = 10'h3C0;
    cyc(90);
    chk("random lock", lock_n, 0);
    chk("word", parallel_out, 10'h3C0);
  endtask
  task t_sleep;
    sleep_n = 0;
    cyc(5);
    chk("tx en_n", ser_out_en_n, 1);
    t_idle;
    loop_en = 1;
    sleep_n = 1;
    cyc(32); // Too soon for random lock, so only sync frames can lock
    chk("sync relock", lock_n, 0);
    loop_en = 0;
  endtask
  task report_and_stop;
    if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {resetn, sync_request_a, sync_request_b, bad, tx_edge_select} = 5'b00010;
    loop_en = 0;
    {sleep_n, rx_output_enable, data_in, rx_word, error_cnt, n_checks} = {2'b11, 20'h0, 64'h0};
    cyc(12);
    t_idle;
    resetn = 1;
    cyc(30);
    t_idle;
    t_sync_tx;
    t_data_tx;
    t_rx_lock;
    t_loss_relock;
    t_sleep;
    report_and_stop;
  end
  initial begin #400000; error_cnt++; report_and_stop; end
endmodule // serdes_link_lock_sync_tb
